// File: adc_timing_and_result_control.sv
// Timing, pin mask and result control for a 10-bit SAR converter
// Assumes the SAR core shares i_clk and holds its result valid in the update cycle
`timescale 1ns/1ps
`default_nettype none

module adc_timing_and_result_control (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_ce,
    input  wire logic [7:0]               i_addr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [7:0]               o_rdata,
    output logic                          o_irq,
    output logic      [7:0]               o_analog_pin_bits,
    output adc_ctrl_pkg::core_req_s       o_core,
    input  wire logic [9:0]               i_core_result
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        adc_ctrl_pkg::ctrl_s                   ctrl;
        adc_ctrl_pkg::timing_s                 timing;
        logic [7:0]                            analog_pin_bits;
        logic [9:0]                            result_value;
        logic [adc_ctrl_pkg::IRQ_BITS-1:0]     irq_status;
        logic [adc_ctrl_pkg::IRQ_BITS-1:0]     irq_enable;
        adc_ctrl_pkg::conv_state_e             state;
        logic [3:0]                            period_cnt;
        logic [7:0]                            rdata;
        logic                                  irq;
        adc_ctrl_pkg::core_req_s               core;
    } ctrl_state_s;

    ctrl_state_s r_reg;
    ctrl_state_s r_next;

    logic       conv_tick;
    logic       div_run;
    logic [4:0] window_sum;
    logic [3:0] window_len;

    // ------------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------------
    assign div_run = (r_reg.state == adc_ctrl_pkg::ST_SAMPLE) ||
                     (r_reg.state == adc_ctrl_pkg::ST_CONVERT);

    adc_conv_clock_divider u_divider (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_run      (div_run),
        .i_div_code (r_reg.timing.conv_clock_divider_code),
        .o_tick     (conv_tick)
    );

    // ------------------------------------------------------------------
    // Sample window length
    // ------------------------------------------------------------------
    always_comb begin
        window_sum = 5'({1'b0, r_reg.timing.sample_length_code} + 5'h01);
        if (window_sum < adc_ctrl_pkg::SAMPLE_MIN_PERIODS) begin
            window_len = adc_ctrl_pkg::SAMPLE_MIN_PERIODS[3:0];
        end else if (window_sum > adc_ctrl_pkg::SAMPLE_MAX_PERIODS) begin
            window_len = adc_ctrl_pkg::SAMPLE_MAX_PERIODS[3:0];
        end else begin
            window_len = window_sum[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic evt_done;
        logic evt_cmp;
        logic hw_go_clear;
        logic load_result;
        logic sw_go_set;

        evt_done    = 1'b0;
        evt_cmp     = 1'b0;
        hw_go_clear = 1'b0;
        load_result = 1'b0;
        sw_go_set   = 1'b0;

        r_next               = r_reg;
        r_next.rdata         = 8'h00;
        r_next.core.bit_step = 1'b0;

        // Conversion sequencer
        unique case (r_reg.state)
            adc_ctrl_pkg::ST_IDLE: begin
                if (r_reg.ctrl.converter_enable && r_reg.ctrl.go) begin
                    r_next.state      = adc_ctrl_pkg::ST_SAMPLE;
                    r_next.period_cnt = 4'h0;
                end
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
                if (conv_tick) begin
                    if (r_reg.period_cnt == 4'(window_len - 4'h1)) begin
                        r_next.state      = adc_ctrl_pkg::ST_CONVERT;
                        r_next.period_cnt = 4'h0;
                    end else begin
                        r_next.period_cnt = 4'(r_reg.period_cnt + 4'h1);
                    end
                end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                if (conv_tick) begin
                    r_next.core.bit_step = 1'b1;
                    if (r_reg.period_cnt == 4'(adc_ctrl_pkg::CONV_STEP_PERIODS - 4'h1)) begin
                        r_next.state      = adc_ctrl_pkg::ST_UPDATE;
                        r_next.period_cnt = 4'h0;
                    end else begin
                        r_next.period_cnt = 4'(r_reg.period_cnt + 4'h1);
                    end
                end
            end
            adc_ctrl_pkg::ST_UPDATE: begin
                if (r_reg.ctrl.compare_mode_on) begin
                    evt_cmp      = (i_core_result > r_reg.result_value);
                    r_next.state = adc_ctrl_pkg::ST_SAMPLE;
                end else begin
                    load_result  = 1'b1;
                    evt_done     = 1'b1;
                    hw_go_clear  = 1'b1;
                    r_next.state = adc_ctrl_pkg::ST_IDLE;
                end
            end
        endcase

        // Disable or software stop aborts the sequence
        if (!r_reg.ctrl.converter_enable ||
            (!r_reg.ctrl.go && r_reg.state != adc_ctrl_pkg::ST_UPDATE)) begin
            r_next.state         = adc_ctrl_pkg::ST_IDLE;
            r_next.period_cnt    = 4'h0;
            r_next.core.bit_step = 1'b0;
        end

        // Register reads
        if (i_rd) begin
            case (i_addr)
                adc_ctrl_pkg::CTRL_ADDR: begin
                    r_next.rdata = {r_reg.ctrl.converter_enable, r_reg.ctrl.conv_flag,
                                    r_reg.ctrl.compare_mode_on, 1'b0,
                                    r_reg.ctrl.input_mux_pick, r_reg.ctrl.go};
                end
                adc_ctrl_pkg::TIMING_ADDR: begin
                    r_next.rdata = {r_reg.timing.conv_clock_divider_code, 1'b0,
                                    r_reg.timing.sample_length_code};
                end
                adc_ctrl_pkg::PIN_MASK_ADDR: begin
                    r_next.rdata = r_reg.analog_pin_bits;
                end
                adc_ctrl_pkg::RESULT_LO_ADDR: begin
                    r_next.rdata = {6'h00, r_reg.result_value[1:0]};
                end
                adc_ctrl_pkg::RESULT_HI_ADDR: begin
                    r_next.rdata = r_reg.result_value[9:2];
                end
                adc_ctrl_pkg::IRQ_STATUS_ADDR: begin
                    r_next.rdata = {6'h00, r_reg.irq_status};
                end
                adc_ctrl_pkg::IRQ_ENABLE_ADDR: begin
                    r_next.rdata = {6'h00, r_reg.irq_enable};
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end

        // Register writes
        if (i_wr) begin
            case (i_addr)
                adc_ctrl_pkg::CTRL_ADDR: begin
                    r_next.ctrl.converter_enable = i_wdata[adc_ctrl_pkg::CTRL_ENABLE_BIT];
                    r_next.ctrl.conv_flag        = i_wdata[adc_ctrl_pkg::CTRL_FLAG_BIT];
                    r_next.ctrl.compare_mode_on  = i_wdata[adc_ctrl_pkg::CTRL_COMPARE_BIT];
                    r_next.ctrl.input_mux_pick   = i_wdata[adc_ctrl_pkg::CTRL_MUX_LSB +: 3];
                    r_next.ctrl.go               = i_wdata[adc_ctrl_pkg::CTRL_GO_BIT];
                    sw_go_set                    = i_wdata[adc_ctrl_pkg::CTRL_GO_BIT];
                end
                adc_ctrl_pkg::TIMING_ADDR: begin
                    r_next.timing.conv_clock_divider_code =
                        i_wdata[adc_ctrl_pkg::TIMING_DIV_LSB +: 3];
                    r_next.timing.sample_length_code =
                        i_wdata[adc_ctrl_pkg::TIMING_LEN_LSB +: 4];
                end
                adc_ctrl_pkg::PIN_MASK_ADDR: begin
                    r_next.analog_pin_bits = i_wdata;
                end
                adc_ctrl_pkg::RESULT_LO_ADDR: begin
                    r_next.result_value[1:0] = i_wdata[1:0];
                end
                adc_ctrl_pkg::RESULT_HI_ADDR: begin
                    r_next.result_value[9:2] = i_wdata;
                end
                adc_ctrl_pkg::IRQ_CLEAR_ADDR: begin
                    r_next.irq_status = r_reg.irq_status & ~i_wdata[adc_ctrl_pkg::IRQ_BITS-1:0];
                end
                adc_ctrl_pkg::IRQ_ENABLE_ADDR: begin
                    r_next.irq_enable = i_wdata[adc_ctrl_pkg::IRQ_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware updates win over software clears
        if (load_result) begin
            r_next.result_value = i_core_result;
        end
        if (hw_go_clear && !sw_go_set) begin
            r_next.ctrl.go = 1'b0;
        end
        if (evt_done || evt_cmp) begin
            r_next.ctrl.conv_flag = 1'b1;
        end
        if (evt_done) begin
            r_next.irq_status[adc_ctrl_pkg::IRQ_DONE_BIT] = 1'b1;
        end
        if (evt_cmp) begin
            r_next.irq_status[adc_ctrl_pkg::IRQ_CMP_BIT] = 1'b1;
        end

        // Interrupt and core outputs
        r_next.irq                 = |(r_next.irq_status & r_next.irq_enable);
        r_next.core.enable         = r_next.ctrl.converter_enable;
        r_next.core.sample         = (r_next.state == adc_ctrl_pkg::ST_SAMPLE);
        r_next.core.input_mux_pick = r_next.ctrl.input_mux_pick;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_reg                 <= '0;
            r_reg.analog_pin_bits <= adc_ctrl_pkg::REG_RESET_VALUE;
            r_reg.state           <= adc_ctrl_pkg::ST_IDLE;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata           = r_reg.rdata;
    assign o_irq             = r_reg.irq;
    assign o_analog_pin_bits = r_reg.analog_pin_bits;
    assign o_core            = r_reg.core;

endmodule : adc_timing_and_result_control

`default_nettype wire

// File: adc_ctrl_pkg.sv
// Constants, types and carriers for the converter timing and result control
// Assumes one system clock domain shared by the register port and the sequencer
package adc_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR       = 8'h93;
    localparam logic [7:0] TIMING_ADDR     = 8'h94;
    localparam logic [7:0] PIN_MASK_ADDR   = 8'h95;
    localparam logic [7:0] RESULT_LO_ADDR  = 8'h96;
    localparam logic [7:0] RESULT_HI_ADDR  = 8'h97;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h98;
    localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'h99;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h9A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_ENABLE_BIT  = 7;
    localparam int unsigned CTRL_FLAG_BIT    = 6;
    localparam int unsigned CTRL_COMPARE_BIT = 5;
    localparam int unsigned CTRL_MUX_LSB     = 1;
    localparam int unsigned CTRL_GO_BIT      = 0;
    localparam int unsigned TIMING_DIV_LSB   = 5;
    localparam int unsigned TIMING_LEN_LSB   = 0;
    localparam int unsigned IRQ_DONE_BIT     = 0;
    localparam int unsigned IRQ_CMP_BIT      = 1;
    localparam int unsigned IRQ_BITS         = 2;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VALUE      = 8'h00;
    localparam logic [4:0] SAMPLE_MIN_PERIODS   = 5'h02;
    localparam logic [4:0] SAMPLE_MAX_PERIODS   = 5'h0F;
    localparam logic [3:0] CONV_STEP_PERIODS    = 4'hC;
    localparam logic [5:0] DIV_PERIODS [0:7]    = '{6'h02, 6'h04, 6'h06, 6'h08,
                                                    6'h0C, 6'h10, 6'h18, 6'h20};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_UPDATE
    } conv_state_e;

    typedef struct packed {
        logic       converter_enable;
        logic       conv_flag;
        logic       compare_mode_on;
        logic [2:0] input_mux_pick;
        logic       go;
    } ctrl_s;

    typedef struct packed {
        logic [2:0] conv_clock_divider_code;
        logic [3:0] sample_length_code;
    } timing_s;

    typedef struct packed {
        logic       enable;
        logic       sample;
        logic       bit_step;
        logic [2:0] input_mux_pick;
    } core_req_s;

endpackage : adc_ctrl_pkg

// File: adc_conv_clock_divider.sv
// Converter clock tick generator, one tick per converter clock period
// Assumes the sequencer holds i_run high only while it counts periods
`timescale 1ns/1ps
`default_nettype none

module adc_conv_clock_divider (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_run,
    input  wire logic [2:0] i_div_code,
    output logic            o_tick
);

    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } div_state_s;

    div_state_s r_reg;
    div_state_s r_next;

    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    always_comb begin
        r_next      = r_reg;
        r_next.tick = 1'b0;
        if (!i_run) begin
            r_next.cnt = 6'h00;
        end else begin
            if (r_reg.cnt == 6'(adc_ctrl_pkg::DIV_PERIODS[i_div_code] - 6'h01)) begin
                r_next.cnt = 6'h00;
            end else begin
                r_next.cnt = 6'(r_reg.cnt + 6'h01);
            end
            // Tick raised one count early, registered tick then lands on the period
            if (r_reg.cnt == 6'(adc_ctrl_pkg::DIV_PERIODS[i_div_code] - 6'h02)) begin
                r_next.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_tick = r_reg.tick;

endmodule : adc_conv_clock_divider

`default_nettype wire

// File: adc_ctrl_sva.sv
// Checker for the converter timing and result control ports
// Assumes i_ce held high and one clock domain
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_sva (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire logic                    i_ce,
    input wire logic [7:0]              i_addr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [7:0]              o_rdata,
    input wire logic                    o_irq,
    input wire logic [7:0]              o_analog_pin_bits,
    input wire adc_ctrl_pkg::core_req_s o_core,
    input wire logic [9:0]              i_core_result
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_reset_clears_out: assert property ($past(i_rst) |->
        o_analog_pin_bits == 8'h00 && !o_irq && o_core == 6'h00)
        else $error("outputs not cleared by reset");
    a_pin_mask_write: assert property (i_wr && i_addr == adc_ctrl_pkg::PIN_MASK_ADDR
        |=> o_analog_pin_bits == $past(i_wdata))
        else $error("pin mask not written");
    a_pin_mask_hold: assert property (!(i_wr && i_addr == adc_ctrl_pkg::PIN_MASK_ADDR)
        |=> $stable(o_analog_pin_bits))
        else $error("pin mask changed without write");
    a_pin_mask_read: assert property (i_rd && i_addr == adc_ctrl_pkg::PIN_MASK_ADDR
        |=> o_rdata == o_analog_pin_bits)
        else $error("pin mask read differs from pins");
    a_step_one_cycle: assert property (o_core.bit_step |=> !o_core.bit_step)
        else $error("bit step pulses too close");
    a_sample_min_len: assert property ($rose(o_core.sample) |-> o_core.sample [*4])
        else $error("sample window too short");
    a_sample_max_len: assert property ($rose(o_core.sample) |->
        ##[1:480] !o_core.sample)
        else $error("sample window too long");
    a_step_after_sample: assert property (o_core.bit_step |->
        !o_core.sample && o_core.enable)
        else $error("bit step outside convert phase");
    a_idle_when_off: assert property (!o_core.enable && !$past(o_core.enable) |->
        !o_core.sample && !o_core.bit_step)
        else $error("converter active while disabled");

    c_sample: cover property ($rose(o_core.sample));
    c_step: cover property (o_core.bit_step);
    c_irq: cover property ($rose(o_irq));
endmodule : adc_ctrl_sva

bind adc_timing_and_result_control adc_ctrl_sva u_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_analog_pin_bits(o_analog_pin_bits), .o_core(o_core),
    .i_core_result(i_core_result));

`default_nettype wire

// File: adc_core_model.sv
// Behavioural SAR core: result valid after twelve bit steps
// Assumes the control block shares i_clk
`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
    input  wire logic                    i_clk,
    input  wire adc_ctrl_pkg::core_req_s i_core,
    input  wire logic [9:0]              i_value,
    output logic      [9:0]              o_result
);
    int   steps = 0;
    logic tog   = 1'b0;

    always @(posedge i_clk) begin
        tog <= ~tog;
        if (!i_core.enable || i_core.sample) steps <= 0;
        else if (i_core.bit_step) steps <= steps + 1;
    end

    // Garbage until the last bit decision
    // Last decision is taken in the cycle of the twelfth step pulse
    assign o_result = ((steps + int'(i_core.bit_step)) >= 12) ? i_value : i_value ^ {10{tog}};
endmodule : adc_core_model

`default_nettype wire

// File: adc_timing_and_result_control_bench.sv
// Self-checking bench for the converter timing and result control
// Assumes the core model on the far side, clock enable held high
`timescale 1ns/1ps
`default_nettype none

module adc_timing_and_result_control_bench;
    logic                    i_clk   = 1'b0;
    logic                    i_rst   = 1'b1;
    logic [7:0]              i_addr  = 8'h00;
    logic [7:0]              i_wdata = 8'h00;
    logic                    i_wr    = 1'b0;
    logic                    i_rd    = 1'b0;
    logic [7:0]              o_rdata;
    logic                    o_irq;
    logic [7:0]              o_analog_pin_bits;
    adc_ctrl_pkg::core_req_s o_core;
    logic [9:0]              i_core_result;
    logic [9:0]              core_value = 10'h000;
    logic [3:0]              ts_tab [0:7] = '{4'h0, 4'hF, 4'h1, 4'hE, 4'h7, 4'h3, 4'hF, 4'h0};
    int                      err_total = 0;
    int                      tests_run = 0;

    always #2 i_clk = ~i_clk;

    adc_timing_and_result_control u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_analog_pin_bits(o_analog_pin_bits), .o_core(o_core),
        .i_core_result(i_core_result));

    adc_core_model u_core (.i_clk(i_clk), .i_core(o_core), .i_value(core_value),
        .o_result(i_core_result));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic lim(input int n, input int l);
        if (n >= l) begin
            err_total++;
            $display("MISMATCH wait expected done seen timeout");
            give_verdict();
        end
    endtask : lim

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(n, 16'(e), 16'(o_rdata));
    endtask : rd

    task automatic count_sample(input int k, output int n);
        n = 0;
        repeat (k) begin
            step();
            if (o_core.sample === 1'b1) n++;
        end
    endtask : count_sample

    task automatic wait_steps(input int k);
        int n;
        int c;
        n = 0;
        c = 0;
        while (n < k && c < 4000) begin
            step();
            c++;
            if (o_core.bit_step === 1'b1) n++;
        end
        lim(c, 4000);
    endtask : wait_steps

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int a = 8'h93; a <= 8'h9A; a++) rd(8'(a), 8'h00, "reset_value");
        rd(8'h80, 8'h00, "unmapped");
        chk("pin_reset", 16'h0000, 16'(o_analog_pin_bits));
    endtask : t_reset

    task automatic t_regs();
        wr(adc_ctrl_pkg::TIMING_ADDR, 8'hFF);
        rd(adc_ctrl_pkg::TIMING_ADDR, 8'hEF, "timing");
        wr(adc_ctrl_pkg::PIN_MASK_ADDR, 8'hA5);
        rd(adc_ctrl_pkg::PIN_MASK_ADDR, 8'hA5, "pin_mask");
        chk("pin_out", 16'h00A5, 16'(o_analog_pin_bits));
        wr(adc_ctrl_pkg::RESULT_LO_ADDR, 8'hFF);
        rd(adc_ctrl_pkg::RESULT_LO_ADDR, 8'h03, "result_lo");
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'h00, "unmapped");
    endtask : t_regs

    task automatic t_conv(input logic [2:0] d, input logic [3:0] t);
        int p;
        int w;
        int s;
        int g;
        int n;
        logic [9:0] v;
        p = int'(adc_ctrl_pkg::DIV_PERIODS[d]);
        w = (t == 4'hF) ? 15 : (t == 4'h0) ? 2 : int'(t) + 1;
        v = {d, t, 3'h5};
        core_value = v;
        wr(adc_ctrl_pkg::IRQ_ENABLE_ADDR, {7'h00, d[0]});
        wr(adc_ctrl_pkg::TIMING_ADDR, {d, 1'b0, t});
        wr(adc_ctrl_pkg::CTRL_ADDR, {4'h8, d, 1'b1});
        s = 0;
        while (o_core.sample !== 1'b1 && s < 200) begin
            step();
            s++;
        end
        lim(s, 200);
        chk("mux", 16'(d), 16'(o_core.input_mux_pick));
        chk("enable", 16'h0001, 16'(o_core.enable));
        s = 0;
        while (o_core.sample === 1'b1 && s < 600) begin
            step();
            s++;
        end
        lim(s, 600);
        chk("sample_len", 16'(w * p), 16'(s));
        n = 0;
        g = 0;
        while (n < 12 && g < 100) begin
            step();
            g++;
            if (o_core.bit_step === 1'b1) begin
                if (n > 0) chk("step_gap", 16'(p), 16'(g));
                n++;
                g = 0;
            end
        end
        lim(g, 100);
        for (int i = 0; i < 40; i++) begin
            step();
            if (o_core.bit_step === 1'b1) n++;
        end
        chk("step_count", 16'd12, 16'(n));
        core_value = ~v;
        rd(adc_ctrl_pkg::CTRL_ADDR, {4'hC, d, 1'b0}, "ctrl_done");
        rd(adc_ctrl_pkg::IRQ_STATUS_ADDR, 8'h01, "status");
        chk("irq", 16'(d[0]), 16'(o_irq));
        rd(adc_ctrl_pkg::RESULT_HI_ADDR, v[9:2], "res_hi");
        rd(adc_ctrl_pkg::RESULT_LO_ADDR, {6'h00, v[1:0]}, "res_lo");
        wr(adc_ctrl_pkg::IRQ_CLEAR_ADDR, 8'h03);
        wr(adc_ctrl_pkg::CTRL_ADDR, {4'h8, d, 1'b0});
        step();
        step();
        chk("irq_clear", 16'h0000, 16'(o_irq));
    endtask : t_conv

    task automatic t_cmp();
        int n;
        wr(adc_ctrl_pkg::RESULT_HI_ADDR, 8'h80);
        wr(adc_ctrl_pkg::RESULT_LO_ADDR, 8'h00);
        wr(adc_ctrl_pkg::IRQ_ENABLE_ADDR, 8'h02);
        wr(adc_ctrl_pkg::TIMING_ADDR, 8'h00);
        core_value = 10'h200;
        wr(adc_ctrl_pkg::CTRL_ADDR, 8'hA1);
        wait_steps(24);
        rd(adc_ctrl_pkg::CTRL_ADDR, 8'hA1, "cmp_equal");
        chk("cmp_irq_low", 16'h0000, 16'(o_irq));
        core_value = 10'h300;
        wait_steps(24);
        repeat (4) step();
        rd(adc_ctrl_pkg::CTRL_ADDR, 8'hE1, "cmp_above");
        chk("cmp_irq_high", 16'h0001, 16'(o_irq));
        rd(adc_ctrl_pkg::RESULT_HI_ADDR, 8'h80, "thr_hi");
        rd(adc_ctrl_pkg::RESULT_LO_ADDR, 8'h00, "thr_lo");
        n = 0;
        while (o_core.sample !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        lim(n, 100);
        wait_steps(1);
        wr(adc_ctrl_pkg::CTRL_ADDR, 8'h80);
        repeat (4) step();
        count_sample(60, n);
        chk("cmp_stop", 16'h0000, 16'(n));
        wr(adc_ctrl_pkg::IRQ_CLEAR_ADDR, 8'h03);
    endtask : t_cmp

    task automatic t_off();
        int n;
        wr(adc_ctrl_pkg::CTRL_ADDR, 8'h01);
        count_sample(100, n);
        chk("off_sample", 16'h0000, 16'(n));
        chk("off_enable", 16'h0000, 16'(o_core.enable));
        wr(adc_ctrl_pkg::CTRL_ADDR, 8'h00);
    endtask : t_off

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_regs();
        for (int i = 0; i < 8; i++) t_conv(3'(i), ts_tab[i]);
        t_cmp();
        t_off();
        give_verdict();
    end
endmodule : adc_timing_and_result_control_bench

`default_nettype wire
